// ---- hw/tmc_timer.sv ----
// Purpose: One 13-bit timer/counter: 5-bit prescale in the low byte, 8-bit high byte.
// Assumes: cnt_pin and gate_pin are synchronised; tick is a one-cycle clock-mode pulse.
// Notes:   A software write in the same cycle as a count event wins for the byte written; a low-byte carry still steps the high byte.
`timescale 1ns/100ps
module tmc_timer
    import tmc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    tmc_tmr_if.tmr    bus
);

    tmc_tmr_state_t s_reg;
    tmc_tmr_state_t s_next;
    logic           qualified;
    logic           event_in;

    always_comb begin
        s_next     = s_reg;
        s_next.ovf = 1'b0;
        // Edge history is tracked even while halted so a restart sees no stale edge
        s_next.pin_d = bus.cnt_pin;
        qualified    = bus.run && (!bus.gate || bus.gate_pin);
        event_in     = bus.src_ext ? (s_reg.pin_d && !bus.cnt_pin) : bus.tick;
        if (qualified && event_in) begin
            // Upper three low bits are left untouched
            s_next.low[TMC_LOW_CNT_BITS-1:0] = s_reg.low[TMC_LOW_CNT_BITS-1:0] + TMC_LOW_STEP;
            if (s_reg.low[TMC_LOW_CNT_BITS-1:0] == TMC_LOW_MAX) begin
                s_next.high = s_reg.high + TMC_HIGH_STEP;
                if (s_reg.high == TMC_HIGH_MAX) begin
                    s_next.ovf = 1'b1;
                end
            end
        end
        if (bus.wr_low) begin
            s_next.low = bus.wdata;
        end
        if (bus.wr_high) begin
            s_next.high = bus.wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= TMC_TMR_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.low  = s_reg.low;
    assign bus.high = s_reg.high;
    assign bus.ovf  = s_reg.ovf;

endmodule

// ---- hw/tmc_top.sv ----
// Purpose: Timer 0 and timer 1 in 13-bit mode behind the special-function register bus.
// Assumes: Control bits (run, gate, source, flag clear, interrupt enable) come as plain ports.
// Notes:   Pins are synchronised by two flops; reads answer one cycle after the strobe.
`timescale 1ns/100ps
module tmc_top
    import tmc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Special-function register bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Control bits, index 0 is timer 0
    input  wire logic [1:0] run_control_bit,
    input  wire logic [1:0] gate_select,
    input  wire logic [1:0] count_source_ext,
    input  wire logic       core_timing_div4,
    input  wire logic [1:0] overflow_flag_clr,
    input  wire logic [1:0] timer_int_enable,
    output logic      [1:0] overflow_flag,
    output logic      [1:0] timer_int_req,
    // Pins
    input  wire logic [1:0] external_interrupt_pin_n,
    input  wire logic       timer0_count_pin,
    input  wire logic       timer1_count_pin,
    output logic            timer0_toggle_pin,
    output logic            timer0_toggle_pin_oe,
    output logic            timer1_toggle_pin,
    output logic            timer1_toggle_pin_oe
);

    localparam int TMC_NUM_TIMERS = 2;

    tmc_top_state_t s_reg;
    tmc_top_state_t s_next;

    logic [3:0] div_last;
    logic       tick;
    logic [1:0] ovf;
    logic [1:0] toggle_en;
    logic [7:0] cnt_low  [TMC_NUM_TIMERS];
    logic [7:0] cnt_high [TMC_NUM_TIMERS];
    logic [7:0] rd_mux;

    tmc_tmr_if tif [TMC_NUM_TIMERS] ();

    // Exact match of the bus address against one register offset
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        addr_hit = (addr == off);
    endfunction

    // Read data for one address; unmapped addresses answer a fixed value
    function automatic logic [7:0] read_value(
        input logic [7:0] addr,
        input logic [7:0] t0_low,
        input logic [7:0] t0_high,
        input logic [7:0] t1_low,
        input logic [7:0] t1_high,
        input logic [7:0] port_mode
    );
        read_value = TMC_UNMAPPED_RD;
        if (addr_hit(addr, TMC_OFF_T0_LOW)) begin
            read_value = t0_low;
        end else if (addr_hit(addr, TMC_OFF_T0_HIGH)) begin
            read_value = t0_high;
        end else if (addr_hit(addr, TMC_OFF_T1_LOW)) begin
            read_value = t1_low;
        end else if (addr_hit(addr, TMC_OFF_T1_HIGH)) begin
            read_value = t1_high;
        end else if (addr_hit(addr, TMC_OFF_P3_MODE1)) begin
            read_value = port_mode;
        end
    endfunction

    // One prescaler serves both timers; only a core-timing change re-phases it
    assign div_last = core_timing_div4 ? TMC_DIV4_LAST : TMC_DIV12_LAST;
    assign tick     = (s_reg.pre >= div_last);

    assign toggle_en[0] = s_reg.port_mode[TMC_BIT_T0_TOGGLE_EN];
    assign toggle_en[1] = s_reg.port_mode[TMC_BIT_T1_TOGGLE_EN];

    generate
        for (genvar i = 0; i < TMC_NUM_TIMERS; i++) begin : g_tmr
            localparam logic [7:0] OFF_LOW  = (i == 0) ? TMC_OFF_T0_LOW  : TMC_OFF_T1_LOW;
            localparam logic [7:0] OFF_HIGH = (i == 0) ? TMC_OFF_T0_HIGH : TMC_OFF_T1_HIGH;

            assign tif[i].run      = run_control_bit[i];
            assign tif[i].gate     = gate_select[i];
            assign tif[i].src_ext  = count_source_ext[i];
            // Gate passes while the active-low interrupt pin sits high
            assign tif[i].gate_pin = s_reg.int_s2[i];
            assign tif[i].cnt_pin  = s_reg.cnt_s2[i];
            assign tif[i].tick     = tick;
            assign tif[i].wr_low   = sfr_wr && addr_hit(sfr_addr, OFF_LOW);
            assign tif[i].wr_high  = sfr_wr && addr_hit(sfr_addr, OFF_HIGH);
            assign tif[i].wdata    = sfr_wdata;

            assign cnt_low[i]  = tif[i].low;
            assign cnt_high[i] = tif[i].high;
            assign ovf[i]      = tif[i].ovf;

            tmc_timer u_timer (
                .clk_sys (clk_sys),
                .rst     (rst),
                .bus     (tif[i])
            );
        end
    endgenerate

    assign rd_mux = read_value(sfr_addr, cnt_low[0], cnt_high[0], cnt_low[1], cnt_high[1], s_reg.port_mode);

    always_comb begin
        s_next = s_reg;

        // Two-flop synchronisers; only the second stage feeds logic
        s_next.int_s1 = external_interrupt_pin_n;
        s_next.int_s2 = s_reg.int_s1;
        s_next.cnt_s1 = {timer1_count_pin, timer0_count_pin};
        s_next.cnt_s2 = s_reg.cnt_s1;

        if (tick) begin
            s_next.pre = TMC_DIV_RST;
        end else begin
            s_next.pre = s_reg.pre + TMC_DIV_STEP;
        end

        if (sfr_wr && addr_hit(sfr_addr, TMC_OFF_P3_MODE1)) begin
            s_next.port_mode = sfr_wdata;
        end

        for (int i = 0; i < TMC_NUM_TIMERS; i++) begin
            // A clear in the overflow cycle loses, so no rollover goes unseen
            if (ovf[i]) begin
                s_next.flag[i] = 1'b1;
            end else if (overflow_flag_clr[i]) begin
                s_next.flag[i] = 1'b0;
            end
            if (ovf[i] && toggle_en[i]) begin
                s_next.tog[i] = !s_reg.tog[i];
            end
        end

        if (sfr_rd) begin
            s_next.rdata = rd_mux;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= TMC_TOP_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sfr_rdata     = s_reg.rdata;
    assign overflow_flag = s_reg.flag;
    assign timer_int_req = s_reg.flag & timer_int_enable;

    // Pins are released when toggling is off; the toggle level is kept meanwhile
    assign timer0_toggle_pin    = s_reg.tog[0];
    assign timer0_toggle_pin_oe = toggle_en[0];
    assign timer1_toggle_pin    = s_reg.tog[1];
    assign timer1_toggle_pin_oe = toggle_en[1];

endmodule

// ---- inc/tmc_pkg.sv ----
// Purpose: Shared constants and state types for the dual 13-bit timer/counter block.
// Assumes: 8-bit special-function register bus, one clock domain (clk_sys).
// Notes:   Offsets are byte addresses in the special-function register space.
package tmc_pkg;

    // Register offsets
    localparam logic [7:0] TMC_OFF_T0_LOW   = 8'h8A;
    localparam logic [7:0] TMC_OFF_T1_LOW   = 8'h8B;
    localparam logic [7:0] TMC_OFF_T0_HIGH  = 8'h8C;
    localparam logic [7:0] TMC_OFF_T1_HIGH  = 8'h8D;
    localparam logic [7:0] TMC_OFF_P3_MODE1 = 8'h96;

    // Reset values
    localparam logic [7:0] TMC_RST_LOW      = 8'h00;
    localparam logic [7:0] TMC_RST_HIGH     = 8'h00;
    localparam logic [7:0] TMC_RST_P3_MODE1 = 8'h00;
    localparam logic [7:0] TMC_RST_RDATA    = 8'h00;
    localparam logic [7:0] TMC_UNMAPPED_RD  = 8'h00;

    // Field positions in the port 3 output-mode register
    localparam int TMC_BIT_T0_TOGGLE_EN = 2;
    localparam int TMC_BIT_T1_TOGGLE_EN = 3;

    // Counter geometry: 5-bit prescale in the low register, 8-bit high register
    localparam int         TMC_LOW_CNT_BITS = 5;
    localparam logic [4:0] TMC_LOW_MAX      = 5'h1F;
    localparam logic [4:0] TMC_LOW_STEP     = 5'h01;
    localparam logic [7:0] TMC_HIGH_MAX     = 8'hFF;
    localparam logic [7:0] TMC_HIGH_STEP    = 8'h01;

    // Clock-mode divider: terminal values of the prescale counter
    localparam logic [3:0] TMC_DIV12_LAST   = 4'hB;
    localparam logic [3:0] TMC_DIV4_LAST    = 4'h3;
    localparam logic [3:0] TMC_DIV_STEP     = 4'h1;
    localparam logic [3:0] TMC_DIV_RST      = 4'h0;

    // State of one timer instance
    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic       pin_d;
        logic       ovf;
    } tmc_tmr_state_t;

    localparam tmc_tmr_state_t TMC_TMR_RST = '{
        low:   TMC_RST_LOW,
        high:  TMC_RST_HIGH,
        pin_d: 1'b0,
        ovf:   1'b0
    };

    // State of the top level
    typedef struct packed {
        logic [1:0] int_s1;
        logic [1:0] int_s2;
        logic [1:0] cnt_s1;
        logic [1:0] cnt_s2;
        logic [3:0] pre;
        logic [7:0] port_mode;
        logic [1:0] flag;
        logic [1:0] tog;
        logic [7:0] rdata;
    } tmc_top_state_t;

    localparam tmc_top_state_t TMC_TOP_RST = '{
        int_s1:    2'h0,
        int_s2:    2'h0,
        cnt_s1:    2'h0,
        cnt_s2:    2'h0,
        pre:       TMC_DIV_RST,
        port_mode: TMC_RST_P3_MODE1,
        flag:      2'h0,
        tog:       2'h0,
        rdata:     TMC_RST_RDATA
    };

endpackage

// ---- inc/tmc_tmr_if.sv ----
// Purpose: Carrier between the top level and one timer instance.
// Assumes: All signals are synchronous to clk_sys.
// Notes:   Pin levels arrive already synchronised.
`timescale 1ns/100ps
interface tmc_tmr_if;
    logic       run;
    logic       gate;
    logic       src_ext;
    logic       gate_pin;
    logic       cnt_pin;
    logic       tick;
    logic       wr_low;
    logic       wr_high;
    logic [7:0] wdata;
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf;

    modport ctl (
        output run, gate, src_ext, gate_pin, cnt_pin, tick, wr_low, wr_high, wdata,
        input  low, high, ovf
    );

    modport tmr (
        input  run, gate, src_ext, gate_pin, cnt_pin, tick, wr_low, wr_high, wdata,
        output low, high, ovf
    );
endinterface

// ---- test/tmc_core_model.sv ----
// Purpose: Processor core side of the register bus.
// Assumes: Strobes change at the falling edge.
// Notes:   A released bus shows inverted values, never stale ones.
`timescale 1ns/100ps
module tmc_core_model (
    input  wire logic       clk_sys,
    output logic      [7:0] sfr_addr,
    output logic            sfr_wr,
    output logic            sfr_rd,
    output logic      [7:0] sfr_wdata,
    input  wire logic [7:0] sfr_rdata
);
    initial begin
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
    end
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_wr = w;
        sfr_rd = !w;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        put(1'b0, a, 8'h00);
        d = sfr_rdata;
    endtask
endmodule

// ---- test/tmc_top_props.sv ----
// Purpose: Port-level properties of tmc_top.
// Assumes: One clock domain, rst active high.
// Notes:   Bound to the design from the bench top.
`timescale 1ns/100ps
module tmc_top_props
    import tmc_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [1:0] run_control_bit,
    input wire logic [1:0] overflow_flag_clr,
    input wire logic [1:0] timer_int_enable,
    input wire logic [1:0] overflow_flag,
    input wire logic [1:0] timer_int_req,
    input wire logic       timer0_toggle_pin,
    input wire logic       timer0_toggle_pin_oe,
    input wire logic       timer1_toggle_pin,
    input wire logic       timer1_toggle_pin_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_wr_t0h;
        sfr_wr && sfr_addr == TMC_OFF_T0_HIGH && !run_control_bit[0];
    endsequence
    sequence s_rd_t0h;
        sfr_rd && sfr_addr == TMC_OFF_T0_HIGH && !run_control_bit[0];
    endsequence
    property p_wr_rd;
        s_wr_t0h ##2 s_rd_t0h |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    property p_unmapped;
        sfr_rd && !(sfr_addr inside {[8'h8A:8'h8D], 8'h96}) |=> sfr_rdata == TMC_UNMAPPED_RD;
    endproperty
    property p_rd_hold;
        !sfr_rd |=> $stable(sfr_rdata);
    endproperty
    property p_int_req;
        timer_int_req == (overflow_flag & timer_int_enable);
    endproperty
    property p_oe;
        sfr_wr && sfr_addr == TMC_OFF_P3_MODE1 |=> timer0_toggle_pin_oe == $past(sfr_wdata[2])
            && timer1_toggle_pin_oe == $past(sfr_wdata[3]);
    endproperty
    property p_sticky;
        overflow_flag[0] && !overflow_flag_clr[0] |=> overflow_flag[0];
    endproperty
    property p_ovf_run;
        $rose(overflow_flag[1]) |-> $past(run_control_bit[1], 2);
    endproperty
    property p_tog0;
        // The flag is set at the same edge as the toggle; it may already stand from an earlier rollover
        $changed(timer0_toggle_pin) |-> $past(timer0_toggle_pin_oe) && overflow_flag[0];
    endproperty
    property p_tog1;
        $changed(timer1_toggle_pin) |-> $past(timer1_toggle_pin_oe) && overflow_flag[1];
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("high byte readback wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_int_req: assert property (p_int_req) else $error("interrupt request wrong");
    a_oe: assert property (p_oe) else $error("toggle enable not taken");
    a_sticky: assert property (p_sticky) else $error("overflow flag lost");
    a_ovf_run: assert property (p_ovf_run) else $error("overflow while halted");
    a_tog0: assert property (p_tog0) else $error("timer 0 pin toggled wrongly");
    a_tog1: assert property (p_tog1) else $error("timer 1 pin toggled wrongly");
endmodule

// ---- test/tmc_top_tb.sv ----
// Purpose: Self-checking bench for tmc_top.
// Assumes: 125 MHz clock, inputs driven at the falling edge.
// Notes:   Tick phase is free-running, so rate checks allow one count.
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tmc_top_tb;
    import tmc_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    wire  [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    wire        sfr_wr, sfr_rd;
    logic [1:0] run_control_bit = 2'h0, gate_select = 2'h0, count_source_ext = 2'h0;
    logic [1:0] overflow_flag_clr = 2'h0, timer_int_enable = 2'h0, external_interrupt_pin_n = 2'h3;
    logic [1:0] cp = 2'h3;
    logic       core_timing_div4 = 1'b0;
    wire  [1:0] overflow_flag, timer_int_req;
    wire        timer0_toggle_pin, timer0_toggle_pin_oe, timer1_toggle_pin, timer1_toggle_pin_oe;
    int         bad_count = 0, samples_checked = 0, cycles = 0, seed = 32'hce12, e;
    logic [7:0] d, v, mdl [int];
    always #4 clk_sys = ~clk_sys;
    tmc_top u_dut (.timer0_count_pin(cp[0]), .timer1_count_pin(cp[1]), .*);
    tmc_core_model u_core (.*);
    task automatic tally_and_finish;
        $display("TB: checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic pulses(input int t, input int n);
        repeat (n) begin
            cp[t] = 1'b0;
            repeat (4) @(negedge clk_sys);
            cp[t] = 1'b1;
            repeat (4) @(negedge clk_sys);
        end
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        mdl.delete();
        for (int a = 8'h88; a < 8'h98; a++) begin
            u_core.get(8'(a), d);
            `CHK(d, 8'h00)
            v = 8'($random(seed));
            u_core.put(1'b1, 8'(a), v);
            mdl[a] = (a inside {[8'h8A:8'h8D], 8'h96}) ? v : 8'h00;
            u_core.get(8'(a), d);
            `CHK(d, mdl[a])
        end
        // Count rate in clock mode, both dividers
        for (int dv = 0; dv < 2; dv++) begin
            u_core.put(1'b1, TMC_OFF_T0_LOW, 8'h00);
            core_timing_div4 = dv[0];
            run_control_bit[0] = 1'b1;
            repeat (dv ? 40 : 120) @(negedge clk_sys);
            run_control_bit[0] = 1'b0;
            u_core.get(TMC_OFF_T0_LOW, d);
            `CHK(d >= 8'd9 && d <= 8'd11, 1'b1)
        end
        // Wrap from the 13-bit maximum on each timer
        for (int t = 0; t < 2; t++) begin
            u_core.put(1'b1, TMC_OFF_P3_MODE1, 8'h0C);
            u_core.put(1'b1, 8'(TMC_OFF_T0_LOW + t), 8'hFF);
            u_core.put(1'b1, 8'(TMC_OFF_T0_HIGH + t), 8'hFF);
            timer_int_enable = 2'h3;
            run_control_bit[t] = 1'b1;
            for (int k = 0; k < 100 && overflow_flag[t] !== 1'b1; k++) @(negedge clk_sys);
            run_control_bit[t] = 1'b0;
            `CHK(overflow_flag[t], 1'b1)
            `CHK(timer_int_req[t], 1'b1)
            `CHK(t ? timer1_toggle_pin : timer0_toggle_pin, 1'b1)
            u_core.get(8'(TMC_OFF_T0_HIGH + t), d);
            `CHK(d, 8'h00)
            u_core.get(8'(TMC_OFF_T0_LOW + t), d);
            `CHK(d[7:5], 3'h7)
            `CHK(d[4:0] < 5'h02, 1'b1)
            overflow_flag_clr[t] = 1'b1;
            @(negedge clk_sys);
            overflow_flag_clr[t] = 1'b0;
            @(negedge clk_sys);
            `CHK(overflow_flag[t], 1'b0)
        end
        // Pin counting with carry, gate and halt
        for (int t = 0; t < 2; t++) begin
            count_source_ext[t] = 1'b1;
            u_core.put(1'b1, 8'(TMC_OFF_T0_LOW + t), 8'h1E);
            u_core.put(1'b1, 8'(TMC_OFF_T0_HIGH + t), 8'h10);
            e = (8'h10 << 5) + 8'h1E + 3;
            run_control_bit[t] = 1'b1;
            pulses(t, 3);
            gate_select[t] = 1'b1;
            external_interrupt_pin_n[t] = 1'b0;
            pulses(t, 2);
            external_interrupt_pin_n[t] = 1'b1;
            pulses(t, 1);
            e = e + 1;
            run_control_bit[t] = 1'b0;
            pulses(t, 1);
            u_core.get(8'(TMC_OFF_T0_LOW + t), d);
            `CHK(d, 8'(e % 32))
            u_core.get(8'(TMC_OFF_T0_HIGH + t), d);
            `CHK(d, 8'(e / 32))
        end
        tally_and_finish();
    end
endmodule
bind tmc_top tmc_top_props u_props (.*);
